// ### include/cbsc_pkg.sv
package cbsc_pkg;

	localparam logic [3:0] CBSC_SYS_CTRL_OFFSET = 4'h0;
	localparam logic [3:0] CBSC_IRQ_STAT_OFFSET = 4'h4;
	localparam logic [3:0] CBSC_MON_OFFSET = 4'h8;

	localparam int CBSC_MGMT_IRQ_FLAG_BIT = 25;
	localparam int CBSC_MGMT_IRQ_MODE_BIT = 24;
	localparam int CBSC_PM_REV_BIT = 23;
	localparam int CBSC_RSVD_DRIVE_BIT = 22;
	localparam int CBSC_SUPPLY_OFF_BIT = 21;
	localparam int CBSC_REDUCED_VIDEO_BIT = 20;
	localparam int CBSC_DMA_REQ_EN_BIT = 19;
	localparam int CBSC_DMA_CHAN_LSB = 16;
	localparam int CBSC_BURST_DN_BIT = 15;
	localparam int CBSC_BURST_UP_BIT = 14;
	localparam int CBSC_ACTIVITY_BIT = 13;
	localparam int CBSC_RSVD_ONE_BIT = 12;
	localparam int CBSC_STREAM_BIT = 11;
	localparam int CBSC_UP_WAIT_BIT = 10;
	localparam int CBSC_DOWN_WAIT_BIT = 9;
	localparam int CBSC_PROBE_BIT = 8;
	localparam int CBSC_AUTO_SW_BIT = 7;
	localparam int CBSC_IDLE_GATE_BIT = 6;

	localparam logic [2:0] CBSC_DMA_CHAN_RESET = 3'h4;
	localparam logic [2:0] CBSC_DMA_CHAN_MASTER = 3'h4;

	typedef struct packed {
		logic mgmtIrqModeEnable;
		logic pmRevisionSelect;
		logic reservedPinDrive;
		logic supplyProtectOff;
		logic reducedVideoEnable;
		logic cardDmaRequestEnable;
		logic [2:0] dmaChannelAssign;
		logic readBurstDownstream;
		logic readBurstUpstream;
		logic autoSwitchAllow;
		logic idleClockGate;
	} cbsc_ctrl_type;

	localparam cbsc_ctrl_type CBSC_CTRL_RESET = '{
		mgmtIrqModeEnable: 1'b0,
		pmRevisionSelect: 1'b0,
		reservedPinDrive: 1'b1,
		supplyProtectOff: 1'b0,
		reducedVideoEnable: 1'b0,
		cardDmaRequestEnable: 1'b0,
		dmaChannelAssign: CBSC_DMA_CHAN_RESET,
		readBurstDownstream: 1'b1,
		readBurstUpstream: 1'b0,
		autoSwitchAllow: 1'b0,
		idleClockGate: 1'b0
	};

	typedef struct packed {
		logic streamActive;
		logic upWait;
		logic downWait;
		logic probeActive;
	} cbsc_stat_type;

	typedef struct packed {
		logic dmaValid;
		logic dmaIs16;
		logic [2:0] dmaChannel;
	} cbsc_dma_type;

endpackage

// ### logic/cbsc_activity_flag.sv
`timescale 1ns/1ps
module cbsc_activity_flag
	import cbsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cardAccess,
	input wire logic readClear,
	output logic flag
);
	logic flag_reg;
	logic flag_next;

	// set beats the read that clears it in the same cycle
	assign flag_next = cardAccess | (flag_reg & ~readClear);
	assign flag = flag_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule // cbsc_activity_flag

// ### logic/cbsc_system_control.sv
// Function
// - mode bit makes power writes raise interrupt
// - bit 23 picks power-management revision
// - bit 22 drives reserved pins low with a high-speed card
// - bit 21 set disables supply protection
// - bit 20 floats address lines A25-A22
// - bit 19 gates card DMA requests
// - channel field maps 8/16-bit, 4 master
// - bit 15 allows downstream read bursts
// - bit 14 allows upstream read bursts
// - activity bit sets on access, read clears
// - bit 12 always reads one
// - bit 11 shows power stream busy
// - bit 10 shows power-up delay
// - bit 9 shows power-down delay
// - bit 8 shows socket probe running
// - bit 7 gates auto switch control
// - bit 6 stops idle high-speed card clocking
// - interrupt flag set on write, write-one clears
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module cbsc_system_control
	import cbsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic socketPowerWrite,
	input wire logic cardAccess,
	input wire logic powerStreamBusy,
	input wire logic powerUpDelay,
	input wire logic powerDownDelay,
	input wire logic cardProbeBusy,
	input wire logic highSpeedCard,
	input wire logic cardIdle,
	input wire logic cardClockStopped,
	input wire logic cardDmaRequest,
	input wire logic legacyAutoSwitch,
	output logic mgmtIrq,
	output logic pmRev11,
	output logic reservedPinOut,
	output logic reservedPinOe,
	output logic supplyProtectOn,
	output logic addrHighFloat,
	output logic dmaRequestOut,
	output cbsc_dma_type dmaSelect,
	output logic burstDownAllow,
	output logic burstUpAllow,
	output logic autoSwitchOn,
	output logic cardFsmClockEnable
);
	cbsc_ctrl_type ctrl_reg;
	cbsc_ctrl_type ctrl_next;
	cbsc_stat_type stat_reg;
	logic irqFlag_reg;
	logic irqFlag_next;
	logic ack_reg;
	logic [31:0] readData_reg;
	logic [31:0] readData_next;
	logic [31:0] sysWord;
	logic activity;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] sync3_reg;
	logic [2:0] syncStable_reg;

	function automatic logic laneBit(input logic [3:0] be, input int bitPos);
		laneBit = be[bitPos / 8];
	endfunction

	function automatic logic wrBit(input logic cur, input int bitPos,
			input logic [3:0] be, input logic [31:0] wd);
		wrBit = laneBit(be, bitPos) ? wd[bitPos] : cur;
	endfunction

	// one-cycle wait state per access, then the answer
	wire accessReq = avs_read | avs_write;
	wire accessDone = accessReq & ack_reg;
	wire selCtrl = avs_address == CBSC_SYS_CTRL_OFFSET;
	wire selMon = avs_address == CBSC_MON_OFFSET;
	wire ctrlWrite = avs_write & accessDone & selCtrl;
	// activity clears on the edge that captures it, so no access is lost
	wire ctrlRead = avs_read & ~ack_reg & selCtrl;
	assign avs_waitrequest = accessReq & ~ack_reg;

	// pins from the socket side; accepted when stages two and three agree
	wire [2:0] pinRaw = {cardDmaRequest, cardIdle, cardClockStopped};
	wire [2:0] pinAgree = ~(sync2_reg ^ sync3_reg);
	wire [2:0] pinClean = (pinAgree & sync2_reg) | (~pinAgree & syncStable_reg);
	wire dmaReqPin = pinClean[2];
	wire idlePin = pinClean[1];
	wire clkStopPin = pinClean[0];

	wire irqClearWrite = ctrlWrite & laneBit(avs_byteenable,
		CBSC_MGMT_IRQ_FLAG_BIT) & avs_writedata[CBSC_MGMT_IRQ_FLAG_BIT];
	wire irqSet = ctrl_reg.mgmtIrqModeEnable & socketPowerWrite;
	assign irqFlag_next = irqSet | (irqFlag_reg & ~irqClearWrite);

	cbsc_activity_flag cbsc_activity_flag_inst (
		.sys_clk(sys_clk),
		.reset(reset),
		.cardAccess(cardAccess),
		.readClear(ctrlRead),
		.flag(activity)
	);

	// status bits take no write data
	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrlWrite) begin
			ctrl_next.mgmtIrqModeEnable = wrBit(ctrl_reg.mgmtIrqModeEnable,
				CBSC_MGMT_IRQ_MODE_BIT, avs_byteenable, avs_writedata);
			ctrl_next.pmRevisionSelect = wrBit(ctrl_reg.pmRevisionSelect,
				CBSC_PM_REV_BIT, avs_byteenable, avs_writedata);
			ctrl_next.reservedPinDrive = wrBit(ctrl_reg.reservedPinDrive,
				CBSC_RSVD_DRIVE_BIT, avs_byteenable, avs_writedata);
			ctrl_next.supplyProtectOff = wrBit(ctrl_reg.supplyProtectOff,
				CBSC_SUPPLY_OFF_BIT, avs_byteenable, avs_writedata);
			ctrl_next.reducedVideoEnable = wrBit(ctrl_reg.reducedVideoEnable,
				CBSC_REDUCED_VIDEO_BIT, avs_byteenable, avs_writedata);
			ctrl_next.cardDmaRequestEnable = wrBit(
				ctrl_reg.cardDmaRequestEnable, CBSC_DMA_REQ_EN_BIT,
				avs_byteenable, avs_writedata);
			if (laneBit(avs_byteenable, CBSC_DMA_CHAN_LSB)) begin
				ctrl_next.dmaChannelAssign =
					avs_writedata[CBSC_DMA_CHAN_LSB +: 3];
			end
			ctrl_next.readBurstDownstream = wrBit(
				ctrl_reg.readBurstDownstream, CBSC_BURST_DN_BIT,
				avs_byteenable, avs_writedata);
			ctrl_next.readBurstUpstream = wrBit(ctrl_reg.readBurstUpstream,
				CBSC_BURST_UP_BIT, avs_byteenable, avs_writedata);
			ctrl_next.autoSwitchAllow = wrBit(ctrl_reg.autoSwitchAllow,
				CBSC_AUTO_SW_BIT, avs_byteenable, avs_writedata);
			ctrl_next.idleClockGate = wrBit(ctrl_reg.idleClockGate,
				CBSC_IDLE_GATE_BIT, avs_byteenable, avs_writedata);
		end
	end

	always_comb begin
		sysWord = 32'h0000_0000;
		sysWord[CBSC_MGMT_IRQ_FLAG_BIT] = irqFlag_reg;
		sysWord[CBSC_MGMT_IRQ_MODE_BIT] = ctrl_reg.mgmtIrqModeEnable;
		sysWord[CBSC_PM_REV_BIT] = ctrl_reg.pmRevisionSelect;
		sysWord[CBSC_RSVD_DRIVE_BIT] = ctrl_reg.reservedPinDrive;
		sysWord[CBSC_SUPPLY_OFF_BIT] = ctrl_reg.supplyProtectOff;
		sysWord[CBSC_REDUCED_VIDEO_BIT] = ctrl_reg.reducedVideoEnable;
		sysWord[CBSC_DMA_REQ_EN_BIT] = ctrl_reg.cardDmaRequestEnable;
		sysWord[CBSC_DMA_CHAN_LSB +: 3] = ctrl_reg.dmaChannelAssign;
		sysWord[CBSC_BURST_DN_BIT] = ctrl_reg.readBurstDownstream;
		sysWord[CBSC_BURST_UP_BIT] = ctrl_reg.readBurstUpstream;
		sysWord[CBSC_ACTIVITY_BIT] = activity;
		sysWord[CBSC_RSVD_ONE_BIT] = 1'b1;
		sysWord[CBSC_STREAM_BIT] = stat_reg.streamActive;
		sysWord[CBSC_UP_WAIT_BIT] = stat_reg.upWait;
		sysWord[CBSC_DOWN_WAIT_BIT] = stat_reg.downWait;
		sysWord[CBSC_PROBE_BIT] = stat_reg.probeActive;
		sysWord[CBSC_AUTO_SW_BIT] = ctrl_reg.autoSwitchAllow;
		sysWord[CBSC_IDLE_GATE_BIT] = ctrl_reg.idleClockGate;
	end

	// unmapped offsets read zero; the flag alias sits at its own word too
	always_comb begin
		readData_next = 32'h0000_0000;
		if (avs_read & ~ack_reg) begin
			if (selCtrl) begin
				readData_next = sysWord;
			end else if (avs_address == CBSC_IRQ_STAT_OFFSET) begin
				readData_next = {31'h0000_0000, irqFlag_reg};
			end else if (selMon) begin
				readData_next = {29'h0000_0000, dmaReqPin, idlePin,
					clkStopPin};
			end
		end else begin
			readData_next = readData_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_reg <= CBSC_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irqFlag_reg <= 1'b0;
		end else begin
			irqFlag_reg <= irqFlag_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= accessReq & ~ack_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			readData_reg <= 32'h0000_0000;
		end else begin
			readData_reg <= readData_next;
		end
	end

	// status levels come from the power switch and probe logic
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stat_reg <= '0;
		end else begin
			stat_reg.streamActive <= powerStreamBusy;
			stat_reg.upWait <= powerUpDelay;
			stat_reg.downWait <= powerDownDelay;
			stat_reg.probeActive <= cardProbeBusy;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync1_reg <= 3'h0;
		end else begin
			sync1_reg <= pinRaw;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync2_reg <= 3'h0;
		end else begin
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sync3_reg <= 3'h0;
		end else begin
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			syncStable_reg <= 3'h0;
		end else begin
			syncStable_reg <= pinClean;
		end
	end

	assign avs_readdata = readData_reg;
	assign mgmtIrq = irqFlag_reg;
	assign pmRev11 = ctrl_reg.pmRevisionSelect;

	// reserved pins: low while driven, else floated
	assign reservedPinOut = 1'b0;
	assign reservedPinOe = highSpeedCard & ctrl_reg.reservedPinDrive;
	assign supplyProtectOn = ~ctrl_reg.supplyProtectOff;
	assign addrHighFloat = ctrl_reg.reducedVideoEnable;
	assign dmaRequestOut = ctrl_reg.cardDmaRequestEnable & dmaReqPin;

	wire [2:0] chan = ctrl_reg.dmaChannelAssign;
	assign dmaSelect.dmaValid = chan != CBSC_DMA_CHAN_MASTER;
	assign dmaSelect.dmaIs16 = chan[2];
	assign dmaSelect.dmaChannel = chan;

	assign burstDownAllow = ctrl_reg.readBurstDownstream;
	assign burstUpAllow = ctrl_reg.readBurstUpstream;
	assign autoSwitchOn = ctrl_reg.autoSwitchAllow & legacyAutoSwitch;

	wire gateIdle = ctrl_reg.idleClockGate & highSpeedCard & idlePin
		& clkStopPin;
	assign cardFsmClockEnable = ~gateIdle;
endmodule // cbsc_system_control

// ### testbench/card_bridge_system_control_tb_top.sv
`timescale 1ns/1ps
module card_bridge_system_control_tb_top
	import cbsc_pkg::*;
;
	logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd, outv;
	logic avs_waitrequest, socketPowerWrite, cardAccess, powerStreamBusy;
	logic powerUpDelay, powerDownDelay, mgmtIrq, pmRev11, reservedPinOut;
	logic reservedPinOe, supplyProtectOn, addrHighFloat, dmaRequestOut;
	logic burstDownAllow, burstUpAllow, autoSwitchOn, cardFsmClockEnable;
	logic cardProbeBusy = 1'b0, highSpeedCard = 1'b0, cardIdle = 1'b0;
	logic cardClockStopped = 1'b0, cardDmaRequest = 1'b0, powerDir = 1'b0;
	logic legacyAutoSwitch = 1'b0, powerReq = 1'b0, touchReq = 1'b0;
	cbsc_dma_type dmaSelect;
	logic [2:0] v;
	int err_count = 0;
	int n_tests = 0;
	always #10 sys_clk = ~sys_clk;
	assign outv = {17'h0, mgmtIrq, pmRev11, reservedPinOe, supplyProtectOn,
		addrHighFloat, dmaRequestOut, burstDownAllow, burstUpAllow,
		autoSwitchOn, cardFsmClockEnable, dmaSelect};
	cbsc_system_control cbsc_system_control_inst (.sys_clk, .reset,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .socketPowerWrite, .cardAccess,
		.powerStreamBusy, .powerUpDelay, .powerDownDelay, .cardProbeBusy,
		.highSpeedCard, .cardIdle, .cardClockStopped, .cardDmaRequest,
		.legacyAutoSwitch, .mgmtIrq, .pmRev11, .reservedPinOut, .reservedPinOe,
		.supplyProtectOn, .addrHighFloat, .dmaRequestOut, .dmaSelect,
		.burstDownAllow, .burstUpAllow, .autoSwitchOn, .cardFsmClockEnable);
	cbsc_card_model cbsc_card_model_inst (.sys_clk, .reset, .powerReq,
		.powerDir, .touchReq, .socketPowerWrite, .cardAccess, .powerStreamBusy,
		.powerUpDelay, .powerDownDelay);
	task automatic test_done();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one access; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic power(input logic up);
		powerDir <= up;
		powerReq <= 1'b1;
		@(posedge sys_clk);
		powerReq <= 1'b0;
	endtask
	task automatic stat(input int n, input logic [31:0] exp);
		repeat (n) @(posedge sys_clk);
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0200_0F00, exp);
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		cardDmaRequest <= 1'b1;
		cardIdle <= 1'b1;
		cardClockStopped <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd, 32'h0044_9000);
		chk(outv, 32'h0000_092C);
		bus(1'b0, CBSC_MON_OFFSET, 32'h0000_0000);
		chk(rd, 32'h0000_0007);
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'h01FF_FFC0);
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd, 32'h01FF_D0C0);
		chk(outv, 32'h0000_27BF);
		for (int i = 0; i < 8; i++) begin
			v = i[2:0];
			bus(1'b1, CBSC_SYS_CTRL_OFFSET, {12'h0, v[0], v, 16'h0});
			chk(outv & 32'h0000_021F, {22'h0, v[0], 4'h0, v != 3'h4, v[2], v});
		end
		highSpeedCard <= 1'b1;
		legacyAutoSwitch <= 1'b1;
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'h0040_00C0);
		repeat (4) @(posedge sys_clk);
		chk(outv, 32'h0000_1850);
		touchReq <= 1'b1;
		@(posedge sys_clk);
		touchReq <= 1'b0;
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0000_2000, 32'h0000_2000);
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0000_2000, 32'h0000_0000);
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'h0100_0000);
		power(1'b1);
		stat(2, 32'h0200_0800);
		stat(4, 32'h0200_0400);
		bus(1'b0, CBSC_IRQ_STAT_OFFSET, 32'h0000_0000);
		chk(rd & 32'h0000_0001, 32'h0000_0001);
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'h0300_0000);
		chk(outv & 32'h0000_4000, 32'h0000_0000);
		stat(0, 32'h0000_0000);
		power(1'b0);
		stat(8, 32'h0200_0200);
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'h0200_0000);
		power(1'b1);
		stat(14, 32'h0000_0000);
		cardProbeBusy <= 1'b1;
		stat(2, 32'h0000_0100);
		cardProbeBusy <= 1'b0;
		stat(2, 32'h0000_0000);
		avs_byteenable <= 4'h2;
		bus(1'b1, CBSC_SYS_CTRL_OFFSET, 32'hFFFF_FFFF);
		avs_byteenable <= 4'hF;
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd, 32'h0000_D000);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		bus(1'b0, CBSC_SYS_CTRL_OFFSET, 32'h0000_0000);
		chk(rd, 32'h0044_9000);
		test_done();
	end
endmodule // card_bridge_system_control_tb_top

// ### testbench/cbsc_card_model.sv
`timescale 1ns/1ps
module cbsc_card_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic powerReq,
	input wire logic powerDir,
	input wire logic touchReq,
	output logic socketPowerWrite,
	output logic cardAccess,
	output logic powerStreamBusy,
	output logic powerUpDelay,
	output logic powerDownDelay
);
	logic [3:0] seqCnt_reg;
	logic upDir_reg;
	wire settling = seqCnt_reg != 4'h0 && seqCnt_reg < 4'h7;
	assign socketPowerWrite = powerReq;
	assign cardAccess = touchReq;
	// switch stream runs six cycles, then six of settling
	assign powerStreamBusy = seqCnt_reg > 4'h6;
	assign powerUpDelay = settling && upDir_reg;
	assign powerDownDelay = settling && !upDir_reg;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			seqCnt_reg <= 4'h0;
			upDir_reg <= 1'b0;
		end else if (powerReq) begin
			seqCnt_reg <= 4'hC;
			upDir_reg <= powerDir;
		end else if (seqCnt_reg != 4'h0) begin
			seqCnt_reg <= seqCnt_reg - 4'h1;
		end
	end
endmodule // cbsc_card_model

// ### testbench/cbsc_system_control_sva.sv
`timescale 1ns/1ps
module cbsc_system_control_sva
	import cbsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic socketPowerWrite,
	input wire logic mgmtIrq,
	input wire logic pmRev11,
	input wire logic supplyProtectOn,
	input wire logic addrHighFloat,
	input wire logic reservedPinOut,
	input wire logic reservedPinOe,
	input wire cbsc_dma_type dmaSelect,
	input wire logic legacyAutoSwitch,
	input wire logic autoSwitchOn,
	input wire logic highSpeedCard,
	input wire logic cardFsmClockEnable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence s_wr;
		avs_write && !avs_waitrequest;
	endsequence
	sequence s_rd0;
		avs_read && !avs_waitrequest && avs_address == CBSC_SYS_CTRL_OFFSET;
	endsequence
	property p_ctrl;
		$changed({pmRev11, supplyProtectOn, addrHighFloat}) |-> $past(avs_write);
	endproperty
	property p_rsvd;
		reservedPinOut == 1'b0 && (!reservedPinOe || highSpeedCard);
	endproperty
	property p_chan;
		dmaSelect.dmaValid == (dmaSelect.dmaChannel != CBSC_DMA_CHAN_MASTER)
			&& dmaSelect.dmaIs16 == dmaSelect.dmaChannel[2];
	endproperty
	property p_irq_set;
		$rose(mgmtIrq) |-> $past(socketPowerWrite);
	endproperty
	property p_irq_clr;
		$fell(mgmtIrq) |-> $past(avs_write);
	endproperty
	property p_auto;
		autoSwitchOn |-> legacyAutoSwitch;
	endproperty
	property p_gate;
		!cardFsmClockEnable |-> highSpeedCard;
	endproperty
	property p_one;
		s_rd0 |-> avs_readdata[CBSC_RSVD_ONE_BIT];
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control out moved");
	a_rsvd: assert property (p_rsvd) else $error("pin not low");
	a_chan: assert property (p_chan) else $error("bad dma decode");
	a_irq_set: assert property (p_irq_set) else $error("irq rise");
	a_irq_clr: assert property (p_irq_clr) else $error("irq fall");
	a_auto: assert property (p_auto) else $error("auto switch");
	a_gate: assert property (p_gate) else $error("clock gated");
	a_one: assert property (p_one) else $error("bit12 low");
endmodule // cbsc_system_control_sva
bind cbsc_system_control cbsc_system_control_sva cbsc_system_control_sva_inst (
	.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .socketPowerWrite, .mgmtIrq, .pmRev11, .supplyProtectOn,
	.addrHighFloat, .reservedPinOut, .reservedPinOe, .dmaSelect,
	.legacyAutoSwitch, .autoSwitchOn, .highSpeedCard, .cardFsmClockEnable);
